/* verilog/sar_pkg.sv */
// Purpose: shared constants and types for the stereo serial audio receiver
// Assumes: format and word-length codes come from the host's control
//          register, which sits outside this block
// Notes: the codes, word lengths and reset values used by the design files live here
package sar_pkg;

  // framing codes, as held in the host control register
  localparam logic [1:0] SAR_FMT_I2S = 2'h0;
  localparam logic [1:0] SAR_FMT_LJ = 2'h1;
  localparam logic [1:0] SAR_FMT_RJ = 2'h2;

  // word length codes
  localparam logic [1:0] SAR_WL_16 = 2'h0;
  localparam logic [1:0] SAR_WL_20 = 2'h1;
  localparam logic [1:0] SAR_WL_24 = 2'h2;

  // subaddress of the host control register that carries the framing
  localparam logic [7:0] SAR_CFG_SUBADDR = 8'h04;

  localparam int SAR_SAMPLE_W = 24;
  localparam int SAR_CNT_W = 7;

  // word lengths in bits, counter ceiling and step, at counter width
  localparam logic [6:0] SAR_BITS_16 = 7'h10;
  localparam logic [6:0] SAR_BITS_20 = 7'h14;
  localparam logic [6:0] SAR_BITS_24 = 7'h18;
  localparam logic [6:0] SAR_CNT_MAX = 7'h7F;
  localparam logic [6:0] SAR_CNT_ONE = 7'h01;

  // reset values
  localparam logic [1:0] SAR_FMT_RST = SAR_FMT_I2S;
  localparam logic [1:0] SAR_WL_RST = SAR_WL_24;
  localparam logic [23:0] SAR_WORD_RST = 24'h000000;

  // link-side state, clocked by the bit clock
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [3:0] cfg_meta;
    logic [3:0] cfg_sync;
    logic lr_prev;
    logic locked;
    logic [6:0] cnt;
    logic [23:0] shreg;
    logic [23:0] left_word;
    logic [23:0] right_word;
    logic pair_toggle;
  } sar_link_state_t;

  // core-side state, clocked by clk
  typedef struct packed {
    logic [1:0] fmt;
    logic [1:0] wlen;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [23:0] left;
    logic [23:0] right;
    logic valid;
  } sar_core_state_t;

endpackage

/* verilog/sar_link_if.sv */
// Purpose: carries words and framing setup between the bit clock side
//          and the system clock side of the receiver
// Assumes: words are held stable for at least one slot after each toggle
// Notes: no clock inside; each side samples with its own clock
`timescale 1ns/1ps
interface sar_link_if;
  logic [23:0] left_word;
  logic [23:0] right_word;
  logic pair_toggle;
  logic [1:0] fmt;
  logic [1:0] wlen;

  modport link (
    output left_word,
    output right_word,
    output pair_toggle,
    input fmt,
    input wlen
  );

  modport core (
    input left_word,
    input right_word,
    input pair_toggle,
    output fmt,
    output wlen
  );
endinterface

/* verilog/sar_core_side.sv */
// Purpose: system clock side: holds framing setup, takes word pairs
//          over from the bit clock side and strobes them out
// Assumes: rst_n synchronous active low on clk
// Notes: word buses are quasi-static; only the toggle is synchronised
`timescale 1ns/1ps
module sar_core_side
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] format_sel,
  input wire logic [1:0] word_len_sel,
  sar_link_if.core lk,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample,
  output logic sample_valid
);

  sar_core_state_t q_reg;
  sar_core_state_t q_next;

  always_comb begin
    q_next = q_reg;
    q_next.fmt = format_sel;
    q_next.wlen = word_len_sel;
    q_next.tog_meta = lk.pair_toggle;
    q_next.tog_sync = q_reg.tog_meta;
    q_next.tog_seen = q_reg.tog_sync;
    q_next.valid = 1'b0;
    // words settled long before the toggle gets through two flops
    if (q_reg.tog_sync != q_reg.tog_seen) begin
      q_next.left = lk.left_word;
      q_next.right = lk.right_word;
      q_next.valid = 1'b1;
    end
    if (!rst_n) begin
      q_next.fmt = SAR_FMT_RST;
      q_next.wlen = SAR_WL_RST;
      q_next.tog_meta = 1'b0;
      q_next.tog_sync = 1'b0;
      q_next.tog_seen = 1'b0;
      q_next.left = SAR_WORD_RST;
      q_next.right = SAR_WORD_RST;
      q_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q_reg <= q_next;
  end

  assign lk.fmt = q_reg.fmt;
  assign lk.wlen = q_reg.wlen;
  assign left_sample = q_reg.left;
  assign right_sample = q_reg.right;
  assign sample_valid = q_reg.valid;

endmodule

/* verilog/sar_receiver.sv */
// Purpose: two-channel serial audio receiver, bit clock side and top
// Assumes: bit_clk, frame_select and serial_audio_in come from the sender;
//          frame_select and data are launched on the falling bit clock edge
// Notes: framing and word length are host control bits, sampled on clk
//        and carried into the bit clock domain through two flops
`timescale 1ns/1ps

module sar_receiver
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_clk,
  input wire logic frame_select,
  input wire logic serial_audio_in,
  input wire logic [1:0] format_sel,
  input wire logic [1:0] word_len_sel,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample,
  output logic sample_valid
);

  sar_link_if lk ();

  sar_link_state_t q_reg;
  sar_link_state_t q_next;

  // length of the word in bits, from the length code
  function automatic logic [6:0] word_bits(input logic [1:0] code);
    logic [6:0] r;
    r = SAR_BITS_24;
    case (code)
      SAR_WL_16: r = SAR_BITS_16;
      SAR_WL_20: r = SAR_BITS_20;
      SAR_WL_24: r = SAR_BITS_24;
      default: r = SAR_BITS_24;
    endcase
    return r;
  endfunction

  // sign-extend the low bits of a raw word to the full sample width
  function automatic logic [23:0] sign_fill(
    input logic [23:0] raw,
    input logic [1:0] code
  );
    logic [23:0] r;
    r = raw;
    case (code)
      SAR_WL_16: r = {{8{raw[15]}}, raw[15:0]};
      SAR_WL_20: r = {{4{raw[19]}}, raw[19:0]};
      default: r = raw;
    endcase
    return r;
  endfunction

  logic [1:0] cur_fmt;
  logic [1:0] cur_wl;
  logic [6:0] wbits;
  logic [6:0] last_idx;
  logic changed;
  logic aligned;
  logic [6:0] pos;
  logic [23:0] shifted;
  logic take;
  logic take_left;
  logic [23:0] take_raw;

  always_comb begin
    q_next = q_reg;
    cur_fmt = q_reg.cfg_sync[3:2];
    cur_wl = q_reg.cfg_sync[1:0];
    wbits = word_bits(cur_wl);
    last_idx = wbits - SAR_CNT_ONE;
    take = 1'b0;
    take_left = 1'b0;
    take_raw = SAR_WORD_RST;

    // reset and setup cross into the bit clock domain on two flops
    q_next.rst_meta = rst_n;
    q_next.rst_sync = q_reg.rst_meta;
    q_next.cfg_meta = {lk.fmt, lk.wlen};
    q_next.cfg_sync = q_reg.cfg_meta;

    // both lines sampled on the rising edge of the bit clock
    changed = frame_select != q_reg.lr_prev;
    aligned = q_reg.locked | changed;
    shifted = {q_reg.shreg[22:0], serial_audio_in};
    q_next.shreg = shifted;
    q_next.lr_prev = frame_select;

    // slot position since the last frame select edge; saturates so an
    // overlong slot never wraps into a false capture
    if (changed) begin
      pos = '0;
    end else if (q_reg.cnt != SAR_CNT_MAX) begin
      pos = q_reg.cnt + SAR_CNT_ONE;
    end else begin
      pos = q_reg.cnt;
    end
    q_next.cnt = pos;
    if (changed) begin
      q_next.locked = 1'b1;
    end

    case (cur_fmt)
      SAR_FMT_I2S: begin
        // data index trails the slot position by one clock, so the old
        // count is the index; a 24-bit word in a 24-clock slot ends on
        // the next slot's first clock and is still caught here
        if (q_reg.locked && q_reg.cnt == last_idx) begin
          take = 1'b1;
          take_left = ~q_reg.lr_prev;
          take_raw = shifted;
        end
      end
      SAR_FMT_LJ: begin
        // MSB sits in the edge's own period, index equals position
        if (aligned && pos == last_idx) begin
          take = 1'b1;
          take_left = frame_select;
          take_raw = shifted;
        end
      end
      SAR_FMT_RJ: begin
        // slot just ended: its last bits, LSB last, hold the word
        if (q_reg.locked && changed) begin
          take = 1'b1;
          take_left = q_reg.lr_prev;
          take_raw = q_reg.shreg;
        end
      end
      default: begin
        take = 1'b0;
      end
    endcase

    // left slot always comes first, so the right word completes a pair
    if (take) begin
      if (take_left) begin
        q_next.left_word = sign_fill(take_raw, cur_wl);
      end else begin
        q_next.right_word = sign_fill(take_raw, cur_wl);
        q_next.pair_toggle = ~q_reg.pair_toggle;
      end
    end

    if (!q_reg.rst_sync) begin
      q_next.cfg_meta = {SAR_FMT_RST, SAR_WL_RST};
      q_next.cfg_sync = {SAR_FMT_RST, SAR_WL_RST};
      q_next.lr_prev = 1'b0;
      q_next.locked = 1'b0;
      q_next.cnt = '0;
      q_next.shreg = SAR_WORD_RST;
      q_next.left_word = SAR_WORD_RST;
      q_next.right_word = SAR_WORD_RST;
      q_next.pair_toggle = 1'b0;
    end
  end

  // reset arrives through the synchroniser fields, so no reset branch;
  // the link state needs running bit clock edges to leave reset
  always_ff @(posedge bit_clk) begin
    q_reg <= q_next;
  end

  assign lk.left_word = q_reg.left_word;
  assign lk.right_word = q_reg.right_word;
  assign lk.pair_toggle = q_reg.pair_toggle;

  sar_core_side u_core (
    .clk(clk),
    .rst_n(rst_n),
    .format_sel(format_sel),
    .word_len_sel(word_len_sel),
    .lk(lk),
    .left_sample(left_sample),
    .right_sample(right_sample),
    .sample_valid(sample_valid)
  );

endmodule

/* testbench/sar_receiver_assertions.sv */
// Purpose: port checks for the serial audio receiver
// Assumes: framing and length inputs are held for whole runs of frames
// Notes: width checks wait for setup to settle, a pair in flight is stale
`timescale 1ns/1ps
module sar_receiver_checker
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] format_sel,
  input wire logic [1:0] word_len_sel,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  input wire logic sample_valid
);
  logic [10:0] age_reg;
  logic [3:0] cfg_reg;
  logic settled;

  // cycles since the setup last changed, saturating
  always_ff @(posedge clk) begin
    cfg_reg <= {format_sel, word_len_sel};
    if (!rst_n || cfg_reg != {format_sel, word_len_sel}) begin
      age_reg <= 11'h000;
    end else if (age_reg != 11'h7FF) begin
      age_reg <= age_reg + 11'h001;
    end
  end
  assign settled = age_reg > 11'h3E8;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence quiet8;
    !sample_valid [*8];
  endsequence

  a_valid_pulse: assert property (sample_valid |=> quiet8)
    else $error("pair strobe not a lone one-cycle pulse");
  a_samples_hold: assert property (!sample_valid |->
    $stable(left_sample) && $stable(right_sample))
    else $error("samples moved without a strobe");
  a_reset_clear: assert property ($rose(rst_n) |-> !sample_valid &&
    left_sample == 24'h000000 && right_sample == 24'h000000)
    else $error("outputs not clear after reset");
  a_left_ext16: assert property (settled && sample_valid &&
    word_len_sel == SAR_WL_16 |-> left_sample[23:16] == {8{left_sample[15]}})
    else $error("left 16-bit sample not sign extended");
  a_right_ext16: assert property (settled && sample_valid &&
    word_len_sel == SAR_WL_16 |-> right_sample[23:16] == {8{right_sample[15]}})
    else $error("right 16-bit sample not sign extended");
  a_left_ext20: assert property (settled && sample_valid &&
    word_len_sel == SAR_WL_20 |-> left_sample[23:20] == {4{left_sample[19]}})
    else $error("left 20-bit sample not sign extended");
  a_right_ext20: assert property (settled && sample_valid &&
    word_len_sel == SAR_WL_20 |-> right_sample[23:20] == {4{right_sample[19]}})
    else $error("right 20-bit sample not sign extended");
  a_off_silent: assert property (settled && format_sel == 2'h3
    |-> !sample_valid)
    else $error("strobe seen with capture switched off");
endmodule

bind sar_receiver sar_receiver_checker sar_receiver_checker_inst (
  .clk, .rst_n, .format_sel, .word_len_sel, .left_sample, .right_sample,
  .sample_valid);

/* testbench/sar_sender.sv */
// Purpose: behavioural sender of framed two-channel serial audio
// Assumes: words are right aligned, ratio and length read at each frame start
// Notes: unused slot positions toggle so masking faults show up
`timescale 1ns/1ps
module sar_sender
  import sar_pkg::*;
(
  output logic bit_clk,
  output logic frame_select,
  output logic sdata,
  input wire logic [1:0] fmt,
  input wire logic [1:0] wlen,
  input wire logic [6:0] ratio,
  input wire logic [23:0] left,
  input wire logic [23:0] right
);
  initial begin
    bit_clk = 1'b0;
    frame_select = 1'b0;
    sdata = 1'b0;
  end
  // free running, as a frame clock source does
  always #62.5 bit_clk = ~bit_clk;

  always begin : frame_gen
    int half, w, b;
    logic [23:0] wd;
    // setup may still be unknown at time zero; an empty frame loop
    // would then spin without advancing time
    while ($isunknown({ratio, fmt, wlen})) @(negedge bit_clk);
    half = ratio / 2;
    w = (wlen == SAR_WL_16) ? 16 : (wlen == SAR_WL_20) ? 20 : 24;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < half; k++) begin
        @(negedge bit_clk);
        frame_select <= (fmt == SAR_FMT_I2S) ? s[0] : !s[0];
        wd = s[0] ? right : left;
        b = (fmt == SAR_FMT_RJ) ? k - (half - w) : k;
        if (fmt == SAR_FMT_I2S) begin
          // a full slot spills its last bit past the edge
          b = (k == 0) ? half - 1 : k - 1;
          wd = ((k == 0) ^ s[0]) ? right : left;
        end
        if (b >= 0 && b < w) begin
          sdata <= wd[w - 1 - b];
        end else begin
          sdata <= ~sdata;
        end
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the serial audio receiver
// Assumes: sender model runs the link; setup driven as plain levels
// Notes: first pairs after a setup change are stale and skipped
`timescale 1ns/1ps
module tb_top;
  import sar_pkg::*;
  logic clk, rst_n, bck, fs, sd, sv;
  logic [1:0] fmt, wl;
  logic [6:0] ratio;
  logic [23:0] lw, rw, ls, rs;
  int failures, n_checks;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  sar_sender sar_sender_inst (.bit_clk(bck), .frame_select(fs), .sdata(sd),
    .fmt(fmt), .wlen(wl), .ratio(ratio), .left(lw), .right(rw));
  sar_receiver sar_receiver_inst (.clk(clk), .rst_n(rst_n), .bit_clk(bck),
    .frame_select(fs), .serial_audio_in(sd), .format_sel(fmt),
    .word_len_sel(wl), .left_sample(ls), .right_sample(rs),
    .sample_valid(sv));

  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check24(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // fourth strobe is clear of any pair begun under the old setup
  task run_case(input logic [1:0] f, input logic [1:0] w,
      input logic [6:0] r, input logic [23:0] l, input logic [23:0] rr,
      input logic [23:0] el, input logic [23:0] er);
    int n;
    @(posedge clk);
    #1;
    fmt = f; wl = w; ratio = r; lw = l; rw = rr;
    for (int p = 0; p < 4; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (sv !== 1'b1 && n < 2000);
    end
    check24({23'h000000, sv}, 24'h000001);
    check24(ls, el);
    check24(rs, er);
  endtask

  task t_i2s;
    run_case(SAR_FMT_I2S, SAR_WL_16, 7'h40, 24'h008001, 24'h007FFE,
      24'hFF8001, 24'h007FFE);
    run_case(SAR_FMT_I2S, SAR_WL_24, 7'h30, 24'hA5C3E1, 24'h123456,
      24'hA5C3E1, 24'h123456);
    run_case(SAR_FMT_I2S, SAR_WL_16, 7'h20, 24'h00ABCD, 24'h004321,
      24'hFFABCD, 24'h004321);
  endtask

  task t_lj;
    run_case(SAR_FMT_LJ, SAR_WL_20, 7'h30, 24'h080001, 24'h07FFFF,
      24'hF80001, 24'h07FFFF);
    run_case(SAR_FMT_LJ, SAR_WL_24, 7'h40, 24'h800000, 24'h7FFFFF,
      24'h800000, 24'h7FFFFF);
    run_case(SAR_FMT_LJ, SAR_WL_16, 7'h20, 24'h00FFFF, 24'h000001,
      24'hFFFFFF, 24'h000001);
  endtask

  task t_rj;
    run_case(SAR_FMT_RJ, SAR_WL_24, 7'h40, 24'hC00003, 24'h3FFFFC,
      24'hC00003, 24'h3FFFFC);
    run_case(SAR_FMT_RJ, SAR_WL_16, 7'h30, 24'h00F00F, 24'h000FF0,
      24'hFFF00F, 24'h000FF0);
    run_case(SAR_FMT_RJ, SAR_WL_16, 7'h20, 24'h007001, 24'h00800F,
      24'h007001, 24'hFF800F);
  endtask

  task t_off;
    int seen;
    seen = 0;
    @(posedge clk);
    #1;
    fmt = 2'h3;
    repeat (200) @(posedge clk);
    repeat (1600) begin
      @(posedge clk);
      #1;
      if (sv === 1'b1) seen++;
    end
    check24(24'(seen), 24'h000000);
    run_case(SAR_FMT_I2S, SAR_WL_20, 7'h40, 24'h0ABCDE, 24'h054321,
      24'hFABCDE, 24'h054321);
  endtask

  initial begin
    rst_n = 1'b0; fmt = SAR_FMT_I2S; wl = SAR_WL_24; ratio = 7'h40;
    lw = 24'h000000; rw = 24'h000000; failures = 0; n_checks = 0;
    // link side leaves reset only on bit clock edges
    repeat (4) @(posedge bck);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_i2s;
    t_lj;
    t_rj;
    t_off;
    wrap_up;
  end

  initial begin
    #800000;
    failures++;
    wrap_up;
  end
endmodule
